// ---- logic/dfs_fault_capture.sv ----
module dfs_fault_capture
   import dfs_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   input  wire logic                    clk_en,
   input  wire logic [6:0]              avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [31:0]             avs_writedata,
   output logic      [31:0]             avs_readdata,
   output logic                         avs_waitrequest,
   input  wire logic [dfs_pkg::DFS_TAIL_W-1:0] fault_pin,
   input  wire logic [dfs_pkg::DFS_LOW_W-1:0]  low_report,
   input  wire logic                    remote_mode,
   input  wire logic                    controller_message_sent,
   input  wire logic [dfs_pkg::DFS_MSG_W-1:0]  controller_message,
   input  wire logic                    controller_message_error,
   input  wire logic                    maint_read,
   input  wire logic                    variant_bit_two,
   output logic                         irq,
   output logic                         capture_mode
);
   import dfs_pkg::*;

   // ==========================================================
   // reset release
   logic rs1_q;
   logic rs_n;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rs1_q <= 1'b0;
         rs_n  <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rs_n  <= rs1_q;
      end
   end

   // ==========================================================
   // fault pins come from the drive side, so synchronise first
   logic [DFS_TAIL_W-1:0] s1_q;
   logic [DFS_TAIL_W-1:0] s2_q;
   logic [DFS_TAIL_W-1:0] s3_q;
   logic [DFS_TAIL_W-1:0] flt_evt;

   always_ff @(posedge clock or negedge rs_n) begin
      if (!rs_n) begin
         s1_q <= DFS_RST_TAIL;
         s2_q <= DFS_RST_TAIL;
         s3_q <= DFS_RST_TAIL;
      end else if (clk_en) begin
         s1_q <= fault_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // spare positions can never raise a flag
   assign flt_evt = s2_q & ~s3_q & DFS_FLT_VALID; // R11

   // ==========================================================
   // bus slave: one wait state, effect at the ack edge
   logic        wait_q;
   logic [31:0] rdata_q;
   logic [31:0] rmux;
   logic        req;
   logic        acc;
   logic        wr_acc;

   assign req    = avs_read | avs_write;
   assign acc    = req & ~wait_q;
   assign wr_acc = avs_write & ~wait_q;

   always_ff @(posedge clock or negedge rs_n) begin
      if (!rs_n) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h00000000;
      end else if (clk_en) begin
         if (req && wait_q) begin
            wait_q  <= 1'b0;
            rdata_q <= rmux;
         end else begin
            wait_q  <= 1'b1;
         end
      end
   end

   // ==========================================================
   // last message sent, snapshot and capture mode
   logic [DFS_MSG_W-1:0] last_q;
   logic [DFS_MSG_W-1:0] last_d;
   logic [DFS_MSG_W-1:0] snap_q;
   logic                 cap_q;
   logic                 cap_set;
   logic                 cap_clr;

   assign last_d  = controller_message_sent ? controller_message : last_q;
   assign cap_set = controller_message_error & remote_mode;
   assign cap_clr = wr_acc && avs_address == DFS_ADDR_CTRL
                    && avs_writedata[DFS_CTRL_CAP];

   always_ff @(posedge clock or negedge rs_n) begin
      if (!rs_n) begin
         last_q <= '0;
      end else if (clk_en) begin
         last_q <= last_d;
      end
   end

   // the snapshot holds until another remote message error reloads it; leaving capture mode does not change it
   always_ff @(posedge clock or negedge rs_n) begin
      if (!rs_n) begin
         snap_q <= '0;
         cap_q  <= 1'b0;
      end else if (clk_en) begin
         if (cap_set) begin
            snap_q <= last_d; // R01
            cap_q  <= 1'b1;
         end else if (cap_clr) begin
            cap_q  <= 1'b0;
         end
      end
   end

   // ==========================================================
   // sticky fault flags and status, set wins over clear
   logic [DFS_STAT_W-1:0] stat_q;
   logic [DFS_STAT_W-1:0] mask_q;
   logic [DFS_STAT_W-1:0] stat_set;
   logic [DFS_STAT_W-1:0] stat_clr;
   logic                  irq_q;

   assign stat_set = {cap_set, flt_evt};
   assign stat_clr = (wr_acc && avs_address == DFS_ADDR_STAT)
                     ? avs_writedata[DFS_STAT_W-1:0] : '0;

   genvar g;
   generate
      for (g = 0; g < DFS_STAT_W; g++) begin : g_stat
         always_ff @(posedge clock or negedge rs_n) begin
            if (!rs_n) begin
               stat_q[g] <= 1'b0;
            end else if (clk_en) begin
               if (stat_set[g]) begin
                  stat_q[g] <= 1'b1; // R06 R07 R08 R09 R10
               end else if (stat_clr[g]) begin
                  stat_q[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge rs_n) begin
      if (!rs_n) begin
         mask_q <= '0;
      end else if (clk_en && wr_acc && avs_address == DFS_ADDR_MASK) begin
         mask_q <= avs_writedata[DFS_STAT_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge rs_n) begin
      if (!rs_n) begin
         irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   // ==========================================================
   // report assembly, index 63 is report bit 1
   logic [63:0]           rpt;
   logic [DFS_TAIL_W-1:0] tail;
   logic [15:0]           word [0:3];

   // bits 63 and 64 keep their normal meaning during capture
   always_comb begin
      if (cap_q) begin
         tail = {snap_q, stat_q[DFS_BAD_DM], 1'b0}; // R01 R02 R03 R04 R05
      end else begin
         tail = stat_q[DFS_TAIL_W-1:0] & DFS_FLT_VALID; // R11
      end
   end

   assign rpt = {low_report, tail}; // R12

   generate
      for (g = 0; g < 4; g++) begin : g_word
         assign word[g] = rpt[63-16*g -: 16]; // R12
      end
   endgenerate

   // ==========================================================
   // maintenance copy, one word per cycle
   logic       copy_q;
   logic [1:0] cidx_q;
   logic [15:0] mem_rd;

   always_ff @(posedge clock or negedge rs_n) begin
      if (!rs_n) begin
         copy_q <= 1'b0;
         cidx_q <= 2'h0;
      end else if (clk_en) begin
         if (!copy_q && maint_read && variant_bit_two) begin
            copy_q <= 1'b1; // R13
            cidx_q <= 2'h0;
         end else if (copy_q) begin
            cidx_q <= cidx_q + 2'h1;
            if (cidx_q == DFS_COPY_LAST) begin
               copy_q <= 1'b0;
            end
         end
      end
   end

   dfs_maint_mem u_mem (
      .clock  (clock),
      .rs_n   (rs_n),
      .clk_en (clk_en),
      .we     (copy_q),
      .waddr  (DFS_MEM_FIRST + {2'h0, cidx_q}), // R13
      .wdata  (word[cidx_q]),
      .raddr  (avs_address[5:2]),
      .rdata  (mem_rd)
   );

   // ==========================================================
   // read mux, unmapped reads return zero
   always_comb begin
      rmux = 32'h00000000;
      if (avs_address[DFS_MEM_SEL]) begin
         rmux = {16'h0000, mem_rd};
      end else begin
         unique case (avs_address)
            DFS_ADDR_WORD1: rmux = {16'h0000, word[0]};
            DFS_ADDR_WORD2: rmux = {16'h0000, word[1]};
            DFS_ADDR_WORD3: rmux = {16'h0000, word[2]};
            DFS_ADDR_WORD4: rmux = {16'h0000, word[3]};
            DFS_ADDR_STAT:  rmux = {5'h00, stat_q};
            DFS_ADDR_MASK:  rmux = {5'h00, mask_q};
            DFS_ADDR_CTRL:  rmux = {30'h00000000, copy_q, cap_q};
            default:        rmux = 32'h00000000;
         endcase
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign irq             = irq_q;
   assign capture_mode    = cap_q;

   // ==========================================================
   // checks
   a_capture_load: assert property (@(posedge clock) disable iff (!rs_n) // R01
      clk_en && cap_set |=> cap_q && snap_q == $past(last_d))
      else $error("snapshot not loaded on message error");

   a_capture_hold: assert property (@(posedge clock) disable iff (!rs_n) // R01
      cap_q && !(clk_en && cap_clr) && !(clk_en && cap_set) |=> cap_q && $stable(snap_q))
      else $error("snapshot changed while frozen");

   a_msg_kind: assert property (@(posedge clock) disable iff (!rs_n) // R02 R03
      cap_q |-> rpt[64-45] == snap_q[DFS_MSG_KIND] && rpt[64-46] == snap_q[DFS_MSG_SEL])
      else $error("message kind bit misplaced");

   a_msg_cmds: assert property (@(posedge clock) disable iff (!rs_n) // R04 R05
      cap_q |-> rpt[64-47:64-54] == snap_q[DFS_MSG_CMD_H:DFS_MSG_CMD_L]
                && rpt[64-57] == snap_q[DFS_MSG_RMM] && rpt[64-58] == snap_q[DFS_MSG_SMM])
      else $error("command bits misplaced");

   a_spare_zero: assert property (@(posedge clock) disable iff (!rs_n) // R11
      !cap_q |-> (rpt[25:0] & ~DFS_FLT_VALID) == 26'h0000000)
      else $error("spare report bit set");

   a_fault_set: assert property (@(posedge clock) disable iff (!rs_n) // R06
      clk_en && s2_q[64-46] && !s3_q[64-46] |=> stat_q[64-46] ##1 1'b1)
      else $error("seek message fault not latched");

   a_set_wins: assert property (@(posedge clock) disable iff (!rs_n) // R10
      clk_en && flt_evt[64-62] && stat_clr[64-62] |=> stat_q[64-62])
      else $error("clear beat a new event");

   a_pin_to_flag: assert property (@(posedge clock) disable iff (!rs_n) // R07
      clk_en [*2] ##0 $rose(fault_pin[64-44]) ##1 clk_en [*2]
      |=> stat_q[64-44])
      else $error("write data missing flag late");

   a_irq_level: assert property (@(posedge clock) disable iff (!rs_n)
      clk_en && |(stat_q & mask_q) |=> irq_q)
      else $error("interrupt not raised");

   a_copy_seq: assert property (@(posedge clock) disable iff (!rs_n) // R13
      clk_en && !copy_q && maint_read && variant_bit_two ##1 clk_en [*4]
      |-> cidx_q == 2'h3 && $past(cidx_q, 1) == 2'h2 && $past(cidx_q, 2) == 2'h1
          && $past(cidx_q, 3) == 2'h0 && $past(copy_q, 3) ##1 !copy_q)
      else $error("maintenance copy out of order");

   a_word_split: assert property (@(posedge clock) disable iff (!rs_n) // R12
      word[3] == rpt[15:0] && word[0] == rpt[63:48])
      else $error("report words split wrongly");

   a_bus_ack: assert property (@(posedge clock) disable iff (!rs_n)
      clk_en && req && wait_q |=> !wait_q ##1 (wait_q || !$past(clk_en)))
      else $error("waitrequest timing broken");
endmodule

// ---- logic/dfs_pkg.sv ----
// What this block does
// R01: remote message error replaces bits 39-62 with message
// R02: bit 45 marks address or control message
// R03: bit 46 head/cylinder select or offset on
// R04: bits 47-54 offset-in through check-index commands
// R05: bit 57 reset, bit 58 set maintenance mode
// R06: bits 46-49 seek message, head, cylinder, spindle faults
// R07: bits 44,45,50,53 write safety faults
// R08: bits 51,52,54 seek offset, incomplete, end stop
// R09: bits 56-58 write current and head select faults
// R10: bits 59-63 power, temperature, speed, drive message
// R11: spare report bits read as zero
// R12: 64-bit report, bit 1 first, four 16-bit words
// R13: variant bit two read copies words into memory 3-6
package dfs_pkg;
   // ==========================================================
   // bus map, byte addresses
   localparam logic [6:0] DFS_ADDR_WORD1 = 7'h00;
   localparam logic [6:0] DFS_ADDR_WORD2 = 7'h04;
   localparam logic [6:0] DFS_ADDR_WORD3 = 7'h08;
   localparam logic [6:0] DFS_ADDR_WORD4 = 7'h0C;
   localparam logic [6:0] DFS_ADDR_STAT  = 7'h10;
   localparam logic [6:0] DFS_ADDR_MASK  = 7'h14;
   localparam logic [6:0] DFS_ADDR_CTRL  = 7'h18;
   localparam int         DFS_MEM_SEL    = 6;
   // ==========================================================
   // report layout: tail bit k holds report bit 64-k
   localparam int          DFS_TAIL_W    = 26;
   localparam int          DFS_MSG_W     = 24;
   localparam int          DFS_LOW_W     = 38;
   localparam int          DFS_STAT_W    = 27;
   localparam int          DFS_CAP_EVT   = 26;
   localparam logic [25:0] DFS_FLT_VALID = 26'h23FFDFE;
   localparam logic [25:0] DFS_RST_TAIL  = 26'h0000000;
   localparam int          DFS_BAD_DM    = 1;
   // message fields, index in the snapshot is 62 minus report bit
   localparam int          DFS_MSG_KIND  = 17;
   localparam int          DFS_MSG_SEL   = 16;
   localparam int          DFS_MSG_CMD_H = 15;
   localparam int          DFS_MSG_CMD_L = 8;
   localparam int          DFS_MSG_RMM   = 5;
   localparam int          DFS_MSG_SMM   = 4;
   // ==========================================================
   // maintenance memory
   localparam int          DFS_MEM_AW    = 4;
   localparam logic [3:0]  DFS_MEM_FIRST = 4'h3;
   localparam logic [1:0]  DFS_COPY_LAST = 2'h3;
   localparam int          DFS_CTRL_CAP  = 0;
   localparam int          DFS_CTRL_BUSY = 1;
endpackage

// ---- logic/dfs_maint_mem.sv ----
module dfs_maint_mem
   import dfs_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  rs_n,
   input  wire logic                  clk_en,
   input  wire logic                  we,
   input  wire logic [DFS_MEM_AW-1:0] waddr,
   input  wire logic [15:0]           wdata,
   input  wire logic [DFS_MEM_AW-1:0] raddr,
   output logic      [15:0]           rdata
);
   // ==========================================================
   // word array, cleared at reset so reads are defined
   logic [15:0] mem_q [0:(1<<DFS_MEM_AW)-1];

   always_ff @(posedge clock or negedge rs_n) begin
      if (!rs_n) begin
         for (int i = 0; i < (1<<DFS_MEM_AW); i++) begin
            mem_q[i] <= 16'h0000;
         end
      end else if (clk_en && we) begin
         mem_q[waddr] <= wdata;
      end
   end

   assign rdata = mem_q[raddr];
endmodule

// ---- sim/dfs_drive_model.sv ----
// ==========================================================
// drive side: fault lines follow the request after a latency
module dfs_drive_model (
   input  wire logic        clock,
   input  wire logic        slow,
   input  wire logic [25:0] fault_req,
   output logic      [25:0] fault_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [25:0] d1_q;
   logic [25:0] d2_q;
   logic [25:0] d3_q;
   // slow drive answers two cycles later than a prompt one
   always_ff @(posedge clock) begin
      d1_q <= fault_req;
      d2_q <= d1_q;
      d3_q <= d2_q;
   end
   assign fault_pin = slow ? d3_q : d1_q;
endmodule

// ---- sim/tb.sv ----
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); err_count++; end end
// ==========================================================
// bench top
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dfs_pkg::*;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic        mr = 1'b0;
   logic        vb = 1'b0;
   logic        rm = 1'b0;
   logic        ms = 1'b0;
   logic        me = 1'b0;
   logic        slow = 1'b0;
   logic        ce = 1'b1;
   logic [6:0]  addr = 7'h00;
   logic [31:0] wd = 32'h0;
   logic [37:0] lowr = 38'h0;
   logic [23:0] msg = 24'h0;
   logic [25:0] freq = 26'h0;
   logic [25:0] pins;
   logic [31:0] rdq;
   logic        wq;
   logic        irq;
   logic        capm;
   int          err_count = 0;
   int          n_tests = 0;
   int          seed = 15;
   int          r;
   int          i;
   logic [31:0] v;
   logic [31:0] c;
   logic [26:0] st_m;
   logic [26:0] mk_m;
   logic        cap_m;
   logic [23:0] snap_m;
   logic [15:0] mem_m [16];

   dfs_drive_model drv (.clock(clock), .slow(slow), .fault_req(freq), .fault_pin(pins));
   dfs_fault_capture dut (.clock(clock), .rst_n(rst_n), .clk_en(ce), .avs_address(addr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdq),
      .avs_waitrequest(wq), .fault_pin(pins), .low_report(lowr), .remote_mode(rm),
      .controller_message_sent(ms), .controller_message(msg),
      .controller_message_error(me), .maint_read(mr), .variant_bit_two(vb),
      .irq(irq), .capture_mode(capm));

   initial forever #12.5 clock = ~clock;

   // ==========================================================
   // helpers
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clock);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wd <= d;
      @(posedge clock);
      while (wq !== 1'b0) @(posedge clock);
      q = rdq;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   // report bit 1 sits at index 63; capture swaps bits 39-62
   function automatic logic [63:0] rep_m();
      return {lowr, cap_m ? {snap_m, st_m[DFS_BAD_DM], 1'b0} : st_m[25:0]};
   endfunction

   function automatic logic [31:0] word_m(input int w);
      logic [63:0] rp;
      rp = rep_m();
      return {16'h0, rp[63 - 16 * w -: 16]};
   endfunction

   task automatic finish_test();
      if (err_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      tick(20000);
      err_count++;
      finish_test();
   end

   // ==========================================================
   // main sequence
   initial begin
      st_m = '0;
      mk_m = '0;
      cap_m = 1'b0;
      snap_m = '0;
      foreach (mem_m[k]) mem_m[k] = 16'h0;
      tick(16);
      rst_n <= 1'b1;
      tick(3);
      for (r = 0; r < 12; r++) begin
         slow <= r[0];
         rm <= r[2];
         lowr <= 38'({$random(seed), $random(seed)});
         freq <= 26'h0;
         tick(6);
         freq <= 26'($random(seed));
         tick(12);
         st_m[25:0] = st_m[25:0] | (freq & DFS_FLT_VALID);
         if (r % 3 == 1) begin
            msg <= 24'($random(seed));
            ms <= 1'b1;
            tick(1);
            ms <= 1'b0;
            me <= 1'b1;
            tick(1);
            me <= 1'b0;
            if (rm) begin
               cap_m = 1'b1;
               snap_m = msg;
               st_m[DFS_CAP_EVT] = 1'b1;
            end
            tick(3);
         end
         bus(1'b0, DFS_ADDR_STAT, 32'h0, v);
         `CHK("stat", {5'h0, st_m}, v)
         for (i = 0; i < 4; i++) begin
            bus(1'b0, DFS_ADDR_WORD1 + 7'(4 * i), 32'h0, v);
            `CHK("report word", word_m(i), v)
         end
         bus(1'b0, DFS_ADDR_CTRL, 32'h0, v);
         `CHK("ctrl", {31'h0, cap_m}, v)
         `CHK("capture_mode", cap_m, capm)
         c = $random(seed);
         bus(1'b1, DFS_ADDR_MASK, c, v);
         mk_m = c[26:0];
         tick(3);
         `CHK("irq", |(st_m & mk_m), irq)
         // copy without the variant bit must leave memory alone
         vb <= r[1];
         mr <= 1'b1;
         tick(1);
         mr <= 1'b0;
         tick(8);
         if (vb)
            for (i = 0; i < 4; i++) mem_m[3 + i] = 16'(word_m(i));
         for (i = 2; i < 8; i++) begin
            bus(1'b0, 7'h40 + 7'(4 * i), 32'h0, v);
            `CHK("maint mem", {16'h0, mem_m[i]}, v)
         end
         c = $random(seed);
         bus(1'b1, DFS_ADDR_STAT, c, v);
         st_m = st_m & ~c[26:0];
         if (r % 4 == 3) begin
            bus(1'b1, DFS_ADDR_CTRL, 32'h1, v);
            cap_m = 1'b0;
         end
      end
      // a new event in the cycle of its own clear must survive
      slow <= 1'b0;
      freq <= 26'h0;
      tick(8);
      bus(1'b1, DFS_ADDR_STAT, 32'h07FFFFFF, v);
      st_m = '0;
      freq <= 26'h0000004;
      tick(1);
      bus(1'b1, DFS_ADDR_STAT, 32'h00000004, v);
      st_m[2] = 1'b1;
      bus(1'b0, DFS_ADDR_STAT, 32'h0, v);
      `CHK("set wins", {5'h0, st_m}, v)
      // a message error while the clock enable is low is ignored
      ce <= 1'b0;
      rm <= 1'b1;
      me <= 1'b1;
      tick(1);
      me <= 1'b0;
      tick(2);
      ce <= 1'b1;
      tick(3);
      `CHK("frozen capture", cap_m, capm)
      bus(1'b0, DFS_ADDR_STAT, 32'h0, v);
      `CHK("frozen stat", {5'h0, st_m}, v)
      bus(1'b1, DFS_ADDR_WORD1, 32'hFFFF, v);
      bus(1'b0, DFS_ADDR_WORD1, 32'h0, v);
      `CHK("report ro", word_m(0), v)
      bus(1'b0, 7'h1C, 32'h0, v);
      `CHK("unmapped", 32'h0, v)
      finish_test();
   end
endmodule
